/* include/msu_pkg.sv */
// Package for the memory scan unit: register map, fields, codes and timing.
package msu_pkg;
  // Register indices; byte address is four times the index
  localparam int REG_IDX_CONTROL = 0;
  localparam int REG_IDX_SOURCE = 1;
  localparam int REG_IDX_STATUS = 2;
  localparam int REG_BYTES_PER_IDX = 4;
  // scan_control fields
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_FAULT_NMI_ENABLE_BIT = 1;
  localparam int CTL_RESET_BIT = 7;
  // scan_source_config fields
  localparam int CFG_SRC_LSB = 0;
  localparam int CFG_MODE_LSB = 4;
  // scan_status fields
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_OK_BIT = 1;
  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] SOURCE_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h02;
  // Source and mode codes
  localparam logic [1:0] SRC_FLASH = 2'h0;
  localparam logic [1:0] SRC_BOOTAPP = 2'h1;
  localparam logic [1:0] SRC_BOOT = 2'h2;
  localparam logic [1:0] SRC_SIGROW = 2'h3;
  localparam logic [1:0] MODE_RESET_SCAN = 2'h1;
  // Checksum generator
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'h0fff;
  // Timing in clock cycles
  localparam logic [1:0] START_DELAY_CYC = 2'h3;
  localparam int WORD_PERIOD_CYC = 3;
  localparam int INIT_WORD_PERIOD_CYC = 2;
  localparam logic [1:0] WORD_GAP = 2'(WORD_PERIOD_CYC - 3);
  localparam logic [1:0] INIT_WORD_GAP = 2'(INIT_WORD_PERIOD_CYC - 2);

  typedef enum logic [1:0] {st_idle, st_delay, st_fetch, st_wait} msu_state_t;

  typedef struct packed {
    logic req;
    logic [15:0] addr;
  } msu_flash_req_t;

  typedef struct packed {
    logic ack;
    logic [15:0] data;
  } msu_flash_rsp_t;

  typedef struct packed {
    logic access;
    logic internal;
    logic disconnect;
    logic status_rd;
    logic status_wr;
    logic wbusy;
    logic wok;
  } msu_dbg_t;
endpackage

/* design/msu_memory_scan_unit.sv */
// Memory scan unit: flash checksum scanner with APB registers and debug hooks.
`timescale 1ns/1ns
module msu_memory_scan_unit
  import msu_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter logic [15:0] FLASH_LAST = 16'h3fff,
  parameter logic [15:0] SIGROW_BASE = 16'h1100,
  parameter logic [15:0] SIGROW_LAST = 16'h117f
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Flash read port
  output msu_flash_req_t flash_o,
  input wire msu_flash_rsp_t flash_i,
  // Debugger
  input wire msu_dbg_t dbg_in,
  output logic [1:0] dbg_status_mirror,
  // Reset initialization and fuses
  input wire logic reset_init_active,
  input wire logic reset_scan_enable,
  input wire logic [1:0] reset_scan_source_fuse,
  input wire logic [7:0] boot_end_fuse,
  input wire logic [7:0] app_end_fuse,
  output logic hold_in_reset,
  // CPU side
  input wire logic cpu_sleep,
  output logic cpu_stall,
  output logic nmi_req
);

  if (ADDR_W < 4) begin : g_chk_addr
    $error("ADDR_W too small for the register map");
  end
  if (FLASH_LAST[0] != 1'b1 || SIGROW_LAST[0] != 1'b1 || SIGROW_BASE[0] != 1'b0) begin : g_chk_sec
    $error("Section bounds must be word aligned");
  end

  msu_state_t state;
  logic enable;
  logic fault_nmi_enable;
  logic [1:0] src;
  logic [1:0] mode;
  logic rst_pend;
  logic busy;
  logic ok;
  logic dbg_hold;
  logic init_started;
  logic init_scan;
  logic init_fail;
  logic [1:0] cnt;
  logic [15:0] cur_addr;
  logic [15:0] sec_start;
  logic [15:0] sec_end;
  logic [15:0] crc;

  logic [ADDR_W-3:0] widx;
  logic acc_done;
  logic wr_acc;
  logic wr_scan_control;
  logic wr_scan_source_config;
  logic start_sw;
  logic init_go;
  logic dbg_wr;
  logic dbg_abort;
  logic dbg_sched;
  logic start_evt;
  logic strobe_rst;
  logic run_ok;
  logic [1:0] sel_src;
  logic [15:0] next_start;
  logic [15:0] next_end;
  logic [15:0] next_crc;
  logic last_word;
  logic pass;
  logic finish;
  logic [7:0] rd_byte;
  logic hit;

  // One byte through the generator, most significant bit first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    end
    return r;
  endfunction

  // Request decode
  always_comb begin
    widx = paddr[ADDR_W-1:2];
    acc_done = psel && penable && pready;
    wr_acc = acc_done && pwrite && !nmi_req;
    // one write path for CPU and debugger
    wr_scan_control = wr_acc && (widx == (ADDR_W-2)'(REG_IDX_CONTROL));
    wr_scan_source_config = wr_acc && (widx == (ADDR_W-2)'(REG_IDX_SOURCE));
    start_sw = wr_scan_control && pwdata[CTL_ENABLE_BIT];
    init_go = reset_init_active && reset_scan_enable && !init_started;
    dbg_wr = dbg_in.status_wr && !nmi_req;
    dbg_abort = dbg_wr && !dbg_in.wbusy && busy;
    dbg_sched = dbg_wr && dbg_in.wbusy;
    start_evt = start_sw || dbg_sched || init_go;
    strobe_rst = wr_scan_control && pwdata[CTL_RESET_BIT] && (!fault_nmi_enable || !busy);
    // frozen in sleep or while debugger holds it
    run_ok = !dbg_hold && !cpu_sleep && !rst_pend;
  end

  // Section bounds for the scan about to start
  always_comb begin
    sel_src = init_go ? reset_scan_source_fuse : src;
    next_start = 16'h0000;
    case (sel_src)
      SRC_FLASH: next_end = FLASH_LAST;
      SRC_BOOTAPP: next_end = 16'({app_end_fuse, 8'h00} - 16'h0001);
      SRC_BOOT: next_end = 16'({boot_end_fuse, 8'h00} - 16'h0001);
      SRC_SIGROW: begin
        next_start = SIGROW_BASE;
        next_end = SIGROW_LAST;
      end
      default: next_end = FLASH_LAST;
    endcase
  end

  // Word update and completion
  always_comb begin
    // low byte of each word first
    next_crc = crc_byte(crc_byte(crc, flash_i.data[7:0]), flash_i.data[15:8]);
    last_word = (16'(cur_addr + 16'h0001) >= sec_end);
    pass = (next_crc == 16'h0000);
    finish = (state == st_wait) && flash_i.ack && last_word && !rst_pend && !dbg_abort && !start_evt
      && !dbg_in.access;
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable <= CONTROL_RESET[CTL_ENABLE_BIT];
      fault_nmi_enable <= CONTROL_RESET[CTL_FAULT_NMI_ENABLE_BIT];
      src <= SOURCE_RESET[CFG_SRC_LSB +: 2];
      mode <= SOURCE_RESET[CFG_MODE_LSB +: 2];
      rst_pend <= 1'b0;
    end else begin
      rst_pend <= strobe_rst;
      if (rst_pend) begin
        // cleared one cycle after the strobe; NMI enable survives
        enable <= 1'b0;
        src <= SRC_FLASH;
        mode <= 2'h0;
      end else if (init_go) begin
        // reset-time scan leaves its settings visible
        enable <= 1'b1;
        src <= reset_scan_source_fuse;
        mode <= MODE_RESET_SCAN;
      end else begin
        if (wr_scan_control) begin
          enable <= pwdata[CTL_ENABLE_BIT];
        end
        // set only, and only while idle
        if (wr_scan_control && pwdata[CTL_FAULT_NMI_ENABLE_BIT] && !busy) begin
          fault_nmi_enable <= 1'b1;
        end
        if (wr_scan_source_config && !busy) begin
          src <= pwdata[CFG_SRC_LSB +: 2];
          mode <= pwdata[CFG_MODE_LSB +: 2];
        end
      end
    end
  end

  // Debugger hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_hold <= 1'b0;
    end else if (dbg_in.access) begin
      // any device access by the debugger
      dbg_hold <= 1'b1;
    end else if (dbg_in.internal || dbg_in.disconnect || dbg_in.status_rd) begin
      // released by internal access, disconnect or mirror read
      dbg_hold <= 1'b0;
    end
  end

  // Scan engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_idle;
      busy <= STATUS_RESET[STS_BUSY_BIT];
      ok <= STATUS_RESET[STS_OK_BIT];
      cnt <= 2'h0;
      cur_addr <= 16'h0000;
      sec_start <= 16'h0000;
      sec_end <= 16'h0000;
      crc <= CRC_INIT;
      flash_o <= '0;
      nmi_req <= 1'b0;
      init_started <= 1'b0;
      init_scan <= 1'b0;
      init_fail <= 1'b0;
    end else begin
      if (flash_i.ack) begin
        flash_o.req <= 1'b0;
      end
      if (rst_pend) begin
        state <= st_idle;
        busy <= 1'b0;
        ok <= 1'b0;
        flash_o.req <= 1'b0;
      end else if (dbg_abort) begin
        state <= st_idle;
        busy <= 1'b0;
        flash_o.req <= 1'b0;
      end else if (start_evt) begin
        // enable starts a fresh scan, pass flag cleared
        state <= st_delay;
        busy <= 1'b1;
        ok <= 1'b0;
        cnt <= START_DELAY_CYC;
        cur_addr <= next_start;
        sec_start <= next_start;
        sec_end <= next_end;
        crc <= CRC_INIT;
        flash_o.req <= 1'b0;
        if (init_go) begin
          init_started <= 1'b1;
          init_scan <= 1'b1;
        end
      end else if (dbg_in.access && busy && (state == st_fetch || state == st_wait)) begin
        // restart from the section start once released
        state <= st_fetch;
        cnt <= 2'h0;
        cur_addr <= sec_start;
        crc <= CRC_INIT;
        flash_o.req <= 1'b0;
      end else begin
        case (state)
          st_delay: begin
            // delay counts only while allowed to run
            if (run_ok) begin
              if (cnt == 2'h1) begin
                flash_o.req <= 1'b1;
                flash_o.addr <= cur_addr;
                state <= st_wait;
              end else begin
                cnt <= 2'(cnt - 2'h1);
              end
            end
          end
          st_fetch: begin
            if (run_ok) begin
              if (cnt == 2'h0) begin
                flash_o.req <= 1'b1;
                flash_o.addr <= cur_addr;
                state <= st_wait;
              end else begin
                cnt <= 2'(cnt - 2'h1);
              end
            end
          end
          st_wait: begin
            if (flash_i.ack) begin
              crc <= next_crc;
              if (last_word) begin
                state <= st_idle;
                busy <= 1'b0;
                ok <= pass;
                if (!pass && fault_nmi_enable) begin
                  nmi_req <= 1'b1;
                end
                if (init_scan && !pass) begin
                  init_fail <= 1'b1;
                end
                init_scan <= 1'b0;
              end else begin
                cur_addr <= 16'(cur_addr + 16'h0002);
                cnt <= init_scan ? INIT_WORD_GAP : WORD_GAP;
                state <= st_fetch;
              end
            end
          end
          default: state <= st_idle;
        endcase
      end
      if (dbg_wr && !rst_pend) begin
        if (!dbg_in.wok) begin
          ok <= 1'b0;
          if (fault_nmi_enable) begin
            nmi_req <= 1'b1;
          end
        end else if (!busy) begin
          ok <= 1'b1;
        end
      end
    end
  end

  // Register read data
  always_comb begin
    hit = 1'b1;
    rd_byte = 8'h00;
    case (widx)
      (ADDR_W-2)'(REG_IDX_CONTROL): begin
        rd_byte[CTL_ENABLE_BIT] = enable;
        rd_byte[CTL_FAULT_NMI_ENABLE_BIT] = fault_nmi_enable;
      end
      (ADDR_W-2)'(REG_IDX_SOURCE): begin
        rd_byte[CFG_SRC_LSB +: 2] = src;
        rd_byte[CFG_MODE_LSB +: 2] = mode;
      end
      (ADDR_W-2)'(REG_IDX_STATUS): begin
        rd_byte[STS_BUSY_BIT] = busy;
        rd_byte[STS_OK_BIT] = ok && !busy;
      end
      default: hit = 1'b0;
    endcase
  end

  // APB response: one wait-free access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable && !pready;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        pslverr <= !hit;
      end else if (acc_done) begin
        pslverr <= 1'b0;
      end
    end
  end

  // Side outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_stall <= 1'b0;
      hold_in_reset <= 1'b0;
      dbg_status_mirror <= STATUS_RESET[1:0];
    end else begin
      // CPU stalled while the scan owns flash
      cpu_stall <= busy && (state == st_fetch || state == st_wait);
      // device kept in reset on failure
      hold_in_reset <= init_fail || init_scan || init_go;
      dbg_status_mirror <= {ok && !busy, busy};
    end
  end

  // Checks
  chk_nmi_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    nmi_req |=> nmi_req[*8])
    else $error("NMI request withdrawn");

  chk_start_delay: assert property (@(posedge pclk) disable iff (!presetn)
    (start_sw && state == st_idle && !rst_pend && !dbg_in.access) ##1
    (run_ok && !dbg_in.access && !dbg_in.status_wr && !rst_pend)[*3] |=> flash_o.req)
    else $error("Scan did not start three cycles after enable");

  chk_no_early_fetch: assert property (@(posedge pclk) disable iff (!presetn)
    (start_evt && !rst_pend && !dbg_abort) |=> !flash_o.req ##1 !flash_o.req ##1 !flash_o.req)
    else $error("Fetch issued inside start delay");

  chk_held_no_fetch: assert property (@(posedge pclk) disable iff (!presetn)
    (dbg_hold && !start_evt && state != st_wait) |=> !$rose(flash_o.req))
    else $error("Fetch while debugger holds scanner");

  chk_busy_held: assert property (@(posedge pclk) disable iff (!presetn)
    (dbg_hold && busy && state == st_fetch && !dbg_wr && !rst_pend) |=> busy)
    else $error("Busy dropped while held");

  chk_src_locked: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_scan_source_config && busy && !rst_pend) |=> $stable(src) && $stable(mode))
    else $error("Source changed while busy");

  chk_nmi_wr_lock: assert property (@(posedge pclk) disable iff (!presetn)
    (nmi_req && acc_done && pwrite && !rst_pend) |=> $stable(enable) && $stable(src))
    else $error("Write accepted after NMI");

  chk_fail_nmi: assert property (@(posedge pclk) disable iff (!presetn)
    (finish && !pass && fault_nmi_enable) |=> nmi_req && !ok)
    else $error("Failure without NMI");

  chk_ok_cleared: assert property (@(posedge pclk) disable iff (!presetn)
    (start_evt && !rst_pend && !dbg_abort) |=> !ok && busy)
    else $error("Pass flag not cleared on enable");

  chk_reset_strobe: assert property (@(posedge pclk) disable iff (!presetn)
    strobe_rst |=> ##1 (!enable && src == SRC_FLASH && !busy && !ok))
    else $error("Reset strobe did not clear registers");

  chk_stall: assert property (@(posedge pclk) disable iff (!presetn)
    (state == st_wait) ##1 (state == st_wait) |-> cpu_stall)
    else $error("CPU not stalled during scan");

  chk_hold_reset: assert property (@(posedge pclk) disable iff (!presetn)
    init_fail |=> hold_in_reset)
    else $error("Reset hold released after failure");

  cov_pass: cover property (@(posedge pclk) disable iff (!presetn) finish && pass);
  cov_fail_nmi: cover property (@(posedge pclk) disable iff (!presetn) finish && !pass && fault_nmi_enable);
  cov_dbg_restart: cover property (@(posedge pclk) disable iff (!presetn)
    dbg_in.access && busy && state == st_wait);
  cov_reset_scan: cover property (@(posedge pclk) disable iff (!presetn) init_go ##[1:1000] finish);

endmodule

/* testbench/msu_flash_model.sv */
// Flash read port model with a settable answer delay.
`timescale 1ns/1ns
module msu_flash_model
  import msu_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Read port
  input wire msu_flash_req_t flash_o,
  output msu_flash_rsp_t flash_i,
  // Answer delay, at least one cycle
  input wire logic [3:0] ack_delay
);
  logic [7:0] mem [0:1023];
  logic [3:0] cnt;
  logic done;
  logic [15:0] word;
  assign word = {mem[flash_o.addr[9:0] + 10'h1], mem[flash_o.addr[9:0]]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      done <= 1'b0;
      flash_i <= '0;
    end else begin
      flash_i.ack <= 1'b0;
      // Data lines toggle when not answering
      flash_i.data <= ~flash_i.data;
      if (!flash_o.req) begin
        cnt <= 4'h0;
        done <= 1'b0;
      end else if (!done) begin
        cnt <= cnt + 4'h1;
        if (cnt + 4'h1 >= ack_delay) begin
          flash_i <= {1'b1, word};
          done <= 1'b1;
        end
      end
    end
  end
endmodule

/* testbench/tb_flash_crc_scanner.sv */
// Self-checking bench for the memory scan unit.
`timescale 1ns/1ns
module tb_flash_crc_scanner
  import msu_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  msu_flash_req_t flash_o;
  msu_flash_rsp_t flash_i;
  msu_dbg_t dbg_in;
  logic [1:0] mirror, fuse_src;
  logic init_act, init_en, hold, sleep, stall, nmi;
  logic [3:0] ack_delay;
  int errors, cmp_count, n;

  msu_memory_scan_unit #(
    .FLASH_LAST(16'h02ff),
    .SIGROW_BASE(16'h0300),
    .SIGROW_LAST(16'h033f)
  ) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .flash_o(flash_o), .flash_i(flash_i), .dbg_in(dbg_in), .dbg_status_mirror(mirror),
    .reset_init_active(init_act), .reset_scan_enable(init_en), .reset_scan_source_fuse(fuse_src),
    .boot_end_fuse(8'h01), .app_end_fuse(8'h02), .hold_in_reset(hold),
    .cpu_sleep(sleep), .cpu_stall(stall), .nmi_req(nmi)
  );
  msu_flash_model fm (.pclk(pclk), .presetn(presetn), .flash_o(flash_o), .flash_i(flash_i), .ack_delay(ack_delay));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic end_sim();
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic fail_out(input string msg);
    errors++;
    $display("wrong value at %0t: %s", $time, msg);
    end_sim();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic edge1();
    @(posedge pclk);
    #1;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int k;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, 24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
      fail_out("apb timeout");
    rd = prdata;
    serr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic dbg(input logic [6:0] v);
    @(posedge pclk);
    dbg_in <= v;
    @(posedge pclk);
    dbg_in <= '0;
  endtask
  task automatic do_reset(input logic ri);
    @(posedge pclk);
    presetn <= 1'b0;
    {init_act, init_en} <= {ri, ri};
    tick(6);
    presetn <= 1'b1;
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < 3000; k++) begin
      apb(1'b0, 12'h008, 8'h00);
      if (rd[0] === 1'b0)
        return;
    end
    fail_out("scan never ended");
  endtask
  task automatic wait_req();
    int k;
    for (k = 0; k < 40 && flash_o.req !== 1'b1; k++)
      edge1();
    if (flash_o.req !== 1'b1)
      fail_out("no flash request");
  endtask
  task automatic count_rises(input int k);
    logic prev;
    n = 0;
    prev = flash_o.req;
    repeat (k) begin
      edge1();
      if (flash_o.req === 1'b1 && prev !== 1'b1)
        n++;
      prev = flash_o.req;
    end
  endtask
  function automatic logic [15:0] crc_of(input int lo, input int hi);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = lo; i <= hi; i++)
      for (int b = 7; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ fm.mem[i][b]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction
  task automatic seal(input int lo, input int hi);
    logic [15:0] c;
    c = crc_of(lo, hi - 2);
    fm.mem[hi - 1] = c[15:8];
    fm.mem[hi] = c[7:0];
  endtask

  task automatic s_reset_values();
    chk(mirror, 2'b10, "mirror reset");
    apb(1'b0, 12'h000, 8'h00);
    chk(rd, 32'h0, "control reset");
    apb(1'b0, 12'h004, 8'h00);
    chk(rd, 32'h0, "source reset");
    chk(serr, 1'b0, "mapped no error");
    apb(1'b1, 12'h008, 8'h00);
    apb(1'b0, 12'h008, 8'h00);
    chk(rd, 32'h2, "status reset");
    apb(1'b0, 12'h00c, 8'h00);
    chk(serr, 1'b1, "unmapped error");
  endtask
  task automatic s_scan(input logic [1:0] src);
    logic [15:0] first;
    logic ph;
    first = (src == SRC_SIGROW) ? 16'h0300 : 16'h0000;
    apb(1'b1, 12'h004, {6'h0, src});
    apb(1'b1, 12'h000, 8'h01);
    n = 0;
    do begin
      edge1();
      n++;
    end while (flash_o.req !== 1'b1 && n < 9);
    chk(n, 3, "start delay");
    chk(flash_o.addr, first, "section start");
    ph = 1'b0;
    n = 0;
    do begin
      edge1();
      n++;
      ph = ph | !flash_o.req;
    end while (!(ph && flash_o.req === 1'b1) && n < 20);
    chk(n, 32'(ack_delay) + 2, "word spacing");
    chk(flash_o.addr, first + 16'h2, "next word");
    chk(stall, 1'b1, "cpu stall");
    apb(1'b0, 12'h008, 8'h00);
    chk(rd, 32'h1, "busy status");
    wait_idle();
    chk(rd, 32'h2, "pass status");
    chk(stall, 1'b0, "stall released");
  endtask
  task automatic s_busy_lock();
    apb(1'b1, 12'h004, {6'h0, SRC_BOOT});
    apb(1'b1, 12'h000, 8'h01);
    apb(1'b1, 12'h004, {6'h0, SRC_FLASH});
    apb(1'b1, 12'h000, 8'h03);
    apb(1'b0, 12'h004, 8'h00);
    chk(rd, 32'h2, "source locked");
    apb(1'b0, 12'h000, 8'h00);
    chk(rd[1], 1'b0, "nmi enable locked");
    apb(1'b1, 12'h000, 8'h80);
    apb(1'b0, 12'h008, 8'h00);
    chk(rd, 32'h0, "strobe status");
    apb(1'b0, 12'h004, 8'h00);
    chk(rd, 32'h0, "strobe source");
  endtask
  task automatic s_sleep();
    apb(1'b1, 12'h004, {6'h0, SRC_BOOT});
    apb(1'b1, 12'h000, 8'h01);
    sleep <= 1'b1;
    count_rises(12);
    chk(n, 0, "start in sleep");
    chk(stall, 1'b0, "no stall in delay");
    @(posedge pclk);
    sleep <= 1'b0;
    tick(40);
    sleep <= 1'b1;
    tick(2);
    count_rises(12);
    chk(n, 0, "frozen in sleep");
    @(posedge pclk);
    sleep <= 1'b0;
    wait_idle();
    chk(rd, 32'h2, "resumed scan");
  endtask
  task automatic s_debug();
    apb(1'b1, 12'h000, 8'h01);
    tick(30);
    dbg(7'h40);
    tick(2);
    count_rises(12);
    chk(n, 0, "held by debugger");
    chk(mirror[0], 1'b1, "mirror busy");
    apb(1'b0, 12'h008, 8'h00);
    chk(rd[0], 1'b1, "busy while held");
    dbg(7'h08);
    wait_req();
    chk(flash_o.addr, 16'h0, "restart address");
    wait_idle();
    chk(rd, 32'h2, "restart passes");
    apb(1'b1, 12'h000, 8'h01);
    tick(30);
    dbg(7'h40);
    dbg(7'h04);
    dbg(7'h20);
    count_rises(12);
    chk(n, 0, "aborted stays off");
    apb(1'b0, 12'h008, 8'h00);
    chk(rd[0], 1'b0, "abort busy");
    dbg(7'h40);
    dbg(7'h06);
    count_rises(12);
    chk(n, 0, "scheduled waits");
    dbg(7'h10);
    wait_idle();
    chk(rd, 32'h2, "scheduled passes");
    dbg(7'h04);
    apb(1'b0, 12'h008, 8'h00);
    chk(rd, 32'h0, "ok cleared");
    chk(nmi, 1'b0, "no nmi unenabled");
    dbg(7'h05);
    apb(1'b0, 12'h008, 8'h00);
    chk(rd, 32'h2, "ok set idle");
    apb(1'b1, 12'h000, 8'h02);
    dbg(7'h04);
    tick(2);
    chk(nmi, 1'b1, "debug nmi");
  endtask
  task automatic s_fail();
    do_reset(1'b0);
    fm.mem[16] = ~fm.mem[16];
    apb(1'b1, 12'h004, {6'h0, SRC_BOOT});
    apb(1'b1, 12'h000, 8'h02);
    apb(1'b1, 12'h000, 8'h03);
    wait_idle();
    chk(rd, 32'h0, "mismatch ok");
    tick(2);
    chk(nmi, 1'b1, "failure nmi");
    apb(1'b1, 12'h004, {6'h0, SRC_FLASH});
    apb(1'b0, 12'h004, 8'h00);
    chk(rd, 32'h2, "locked after nmi");
    tick(20);
    chk(nmi, 1'b1, "nmi sticky");
  endtask
  task automatic s_boot();
    fuse_src <= SRC_BOOT;
    do_reset(1'b1);
    tick(600);
    chk(hold, 1'b1, "failed boot scan");
    fm.mem[16] = ~fm.mem[16];
    do_reset(1'b1);
    tick(5);
    chk(hold, 1'b1, "hold in scan");
    n = 0;
    while (hold !== 1'b0 && n < 2000) begin
      edge1();
      n++;
    end
    chk(hold, 1'b0, "hold released");
    @(posedge pclk);
    init_act <= 1'b0;
    apb(1'b0, 12'h000, 8'h00);
    chk(rd[0], 1'b1, "enable after boot");
    apb(1'b0, 12'h004, 8'h00);
    chk(rd[5:0], {MODE_RESET_SCAN, 2'h0, SRC_BOOT}, "mode and source");
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {presetn, init_act, init_en, sleep} = '0;
    dbg_in = '0;
    fuse_src = SRC_FLASH;
    ack_delay = 4'h1;
    errors = 0;
    cmp_count = 0;
    for (int i = 0; i < 1024; i++)
      fm.mem[i] = 8'(i * 7 + 3);
    seal(0, 'h0ff);
    seal(0, 'h1ff);
    seal(0, 'h2ff);
    seal('h300, 'h33f);
    do_reset(1'b0);
    s_reset_values();
    for (int s = 0; s < 4; s++)
      s_scan(2'(s));
    ack_delay <= 4'h3;
    s_scan(SRC_BOOT);
    ack_delay <= 4'h1;
    s_busy_lock();
    s_sleep();
    s_debug();
    s_fail();
    s_boot();
    end_sim();
  end
endmodule
